// ==== shared/nbc_pkg.sv ====
// Constants and types shared by the byte access control block.
package nbc_pkg;

   // I/O register selectors on the core's register port.
   localparam logic [1:0] NBC_SEL_ADDR_HIGH = 2'h0;
   localparam logic [1:0] NBC_SEL_ADDR_LOW  = 2'h1;
   localparam logic [1:0] NBC_SEL_DATA      = 2'h2;
   localparam logic [1:0] NBC_SEL_CONTROL   = 2'h3;

   // Control register bit positions.
   localparam int NBC_BIT_READ_STROBE  = 0;
   localparam int NBC_BIT_WRITE_STROBE = 1;
   localparam int NBC_BIT_MASTER_WE    = 2;
   localparam int NBC_BIT_READY_IE     = 3;

   // Geometry.
   localparam int NBC_ADDR_W  = 9;
   localparam int NBC_DEPTH   = 512;

   // Timing.
   localparam int NBC_MWE_WINDOW_CYC   = 4;
   localparam int NBC_WRITE_STALL_CYC  = 2;
   localparam int NBC_READ_STALL_CYC   = 4;
   localparam int NBC_WRITE_OSC_CYC    = 8448;
   localparam int NBC_OSC_RATE_MHZ     = 1;
   localparam int NBC_CLK_RATE_MHZ     = 100;
   localparam int NBC_WRITE_CLK_CYC    =
      NBC_WRITE_OSC_CYC * NBC_CLK_RATE_MHZ / NBC_OSC_RATE_MHZ;

   // Reset values of control state.
   localparam logic [7:0] NBC_CONTROL_RESET = 8'h00;
   localparam logic [7:0] NBC_DATA_RESET    = 8'h00;

   typedef enum logic [1:0] {
      NBC_IDLE,
      NBC_WRITING
   } nbc_state_t;

endpackage

// ==== hw/nbc_tick.sv ====
// Divider that pulses once per cycle of the write timing oscillator.
`timescale 1ns/1ps
`default_nettype none
module nbc_tick #(
   parameter int DIV = 100
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Control
   input  wire logic run,
   output logic      tick
);
   import nbc_pkg::*;

   logic [15:0] cnt_q;

   // The divider restarts with every write so each write has full length.
   always_ff @(posedge clk) begin
      if (!reset_n || !run) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b0;
      end else if (cnt_q == 16'(DIV - 1)) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== hw/nbc_access.sv ====
// Processor access control for the 512-byte nonvolatile data store.
// How it works
// - Nine-bit address over high and low registers selects one of 512 bytes.
// - Address bits 15:9 and control bits 7:4 read as zero.
// - Address is undefined after reset; software loads it before access.
// - Data register feeds write data and receives read data.
// - Ready interrupt holds while enabled, global enable set, strobe clear.
// - Write starts only if strobe set within four cycles of master enable.
// - Master write enable clears itself four cycles after being set.
// - Write strobe with master enable clear does nothing.
// - Write strobe stays set during write, cleared by hardware after.
// - Starting a write stalls the core for two cycles.
// - Read strobe loads data at once and stalls the core four cycles.
// - During a write, reads are blocked and address writes refused.
// - No write while flash self-programming is active.
// - Write timed by 8448 cycles of the 1 MHz oscillator.
// - Write completes even if power-down is entered; oscillator keeps going.
// - A write in progress completes through a reset.
`timescale 1ns/1ps
`default_nettype none
module nbc_access
   import nbc_pkg::*;
#(
   parameter int WRITE_CLK_CYC = nbc_pkg::NBC_WRITE_CLK_CYC,
   parameter int OSC_DIV       = nbc_pkg::NBC_CLK_RATE_MHZ
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Core I/O register port
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [1:0] io_sel,
   input  wire logic [7:0] io_wdata,
   output logic [7:0]      io_rdata,
   // Core status
   input  wire logic       global_int_enable,
   input  wire logic       flash_self_program_enable,
   input  wire logic       power_down,
   output logic            cpu_stall,
   output logic            ready_irq,
   // Storage array port
   output logic            mem_we,
   output logic [8:0]      mem_addr,
   output logic [7:0]      mem_wdata,
   input  wire logic [7:0] mem_rdata,
   output logic            osc_run
);

   logic [NBC_ADDR_W-1:0] addr_q;
   logic [7:0]            data_q;
   logic                  rie_q;
   logic                  mwe_q;
   logic [2:0]            mwe_cnt_q;
   logic                  wstrobe_q;
   logic [2:0]            stall_q;
   logic [31:0]           wcnt_q;
   logic                  osc_tick;
   logic                  wr_ctl;
   logic                  start_wr;
   logic                  do_read;
   logic                  rdy_q;
   nbc_state_t            state_q;

   ////////////////////////////////////////////////////////////////////////

   assign wr_ctl   = io_wr && io_sel == NBC_SEL_CONTROL;
   // Write refused when flash programming is busy or a write runs.
   assign start_wr = wr_ctl && io_wdata[NBC_BIT_WRITE_STROBE] && mwe_q
                     && !wstrobe_q && !flash_self_program_enable;
   assign do_read  = wr_ctl && io_wdata[NBC_BIT_READ_STROBE]
                     && !wstrobe_q;

   ////////////////////////////////////////////////////////////////////////
   // Address register, deliberately not reset.
   // Software must load it before the first access, so no reset value
   // is spent here and a read of it before loading shows unknown bits.

   always_ff @(posedge clk) begin
      if (io_wr && !wstrobe_q) begin
         if (io_sel == NBC_SEL_ADDR_HIGH) begin
            addr_q[8] <= io_wdata[0];
         end else if (io_sel == NBC_SEL_ADDR_LOW) begin
            addr_q[7:0] <= io_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data register.

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         data_q <= NBC_DATA_RESET;
      end else if (do_read) begin
         data_q <= mem_rdata;
      end else if (io_wr && io_sel == NBC_SEL_DATA && !wstrobe_q) begin
         data_q <= io_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Master write enable with its four cycle window.

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mwe_q     <= 1'b0;
         mwe_cnt_q <= 3'h0;
         rie_q     <= 1'b0;
      end else begin
         if (wr_ctl) begin
            rie_q <= io_wdata[NBC_BIT_READY_IE];
         end
         if (wr_ctl && io_wdata[NBC_BIT_MASTER_WE]) begin
            mwe_q     <= 1'b1;
            mwe_cnt_q <= 3'(NBC_MWE_WINDOW_CYC - 1);
         end else if (mwe_q) begin
            if (mwe_cnt_q == 3'h0) begin
               mwe_q <= 1'b0;
            end else begin
               mwe_cnt_q <= mwe_cnt_q - 3'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write cycle. Reset is not applied while a write runs so the cell
   // programming completes; power-down has no effect on it either.

   nbc_tick #(
      .DIV (OSC_DIV)
   ) u_tick (
      .clk     (clk),
      .reset_n (1'b1),
      .run     (wstrobe_q),
      .tick    (osc_tick)
   );

   always_ff @(posedge clk) begin
      if (!reset_n && state_q != NBC_WRITING) begin
         state_q   <= NBC_IDLE;
         wstrobe_q <= 1'b0;
         wcnt_q    <= 32'h0;
         mem_we    <= 1'b0;
      end else begin
         mem_we <= 1'b0;
         case (state_q)
            NBC_IDLE: begin
               if (start_wr) begin
                  state_q   <= NBC_WRITING;
                  wstrobe_q <= 1'b1;
                  wcnt_q    <= 32'h0;
                  mem_we    <= 1'b1;
               end
            end
            NBC_WRITING: begin
               // Ticks count oscillator cycles; strobe writes do nothing.
               if (osc_tick) begin
                  if (wcnt_q == 32'(WRITE_CLK_CYC / OSC_DIV - 1)) begin
                     state_q   <= NBC_IDLE;
                     wstrobe_q <= 1'b0;
                  end else begin
                     wcnt_q <= wcnt_q + 32'h1;
                  end
               end
            end
            default: begin
               state_q   <= NBC_IDLE;
               wstrobe_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mem_addr  <= 9'h000;
         mem_wdata <= 8'h00;
         // A write that outlives reset still needs its timing source.
         osc_run   <= wstrobe_q;
      end else begin
         if (start_wr) begin
            mem_addr  <= addr_q;
            mem_wdata <= data_q;
         end
         // Oscillator held on through the write, and after it for as long as power-down lasts.
         osc_run <= wstrobe_q || start_wr || (osc_run && power_down);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core stall.

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stall_q   <= 3'h0;
         cpu_stall <= 1'b0;
      end else if (do_read) begin
         stall_q   <= 3'(NBC_READ_STALL_CYC - 1);
         cpu_stall <= 1'b1;
      end else if (start_wr) begin
         stall_q   <= 3'(NBC_WRITE_STALL_CYC - 1);
         cpu_stall <= 1'b1;
      end else if (stall_q != 3'h0) begin
         stall_q   <= stall_q - 3'h1;
         cpu_stall <= 1'b1;
      end else begin
         cpu_stall <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data and ready interrupt.

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         io_rdata  <= 8'h00;
         ready_irq <= 1'b0;
         rdy_q     <= 1'b0;
      end else begin
         rdy_q     <= !wstrobe_q;
         ready_irq <= rie_q && global_int_enable && !wstrobe_q;
         case (io_sel)
            NBC_SEL_ADDR_HIGH: io_rdata <= {7'h00, addr_q[8]};
            NBC_SEL_ADDR_LOW:  io_rdata <= addr_q[7:0];
            NBC_SEL_DATA:      io_rdata <= data_q;
            // Read strobe always reads zero once taken.
            NBC_SEL_CONTROL:   io_rdata <= {4'h0, rie_q, mwe_q,
                                            wstrobe_q, 1'b0};
            default:           io_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////

   mwe_window_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_ctl && io_wdata[NBC_BIT_MASTER_WE]) ##1 !wr_ctl [*4] |=> !mwe_q)
      else $error("master enable did not time out");
   no_start_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_ctl && !mwe_q && state_q == NBC_IDLE) |=> !wstrobe_q)
      else $error("write started without master enable");
   wr_stall_a: assert property (@(posedge clk) disable iff (!reset_n)
      (start_wr && !do_read) |=> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
      else $error("write stall not two cycles");
   rd_stall_a: assert property (@(posedge clk) disable iff (!reset_n)
      do_read |=> cpu_stall [*4] ##1 (!cpu_stall || do_read || start_wr))
      else $error("read stall not four cycles");
   rd_data_a: assert property (@(posedge clk) disable iff (!reset_n)
      do_read |=> data_q == $past(mem_rdata))
      else $error("read data not captured");
   addr_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      wstrobe_q |=> addr_q == $past(addr_q))
      else $error("address changed during write");
   strobe_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      start_wr |=> wstrobe_q && mem_we)
      else $error("write strobe not set on start");
   irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      (rie_q && global_int_enable && !wstrobe_q) |=> ready_irq)
      else $error("ready interrupt missing");
   flash_block_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == NBC_IDLE && flash_self_program_enable) |=> !mem_we)
      else $error("write during flash programming");
   ctl_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      io_sel == NBC_SEL_CONTROL |=> io_rdata[7:4] == 4'h0 && !io_rdata[0])
      else $error("reserved control bits not zero");
   // The pulse to the array must follow an armed master enable.
   mwe_need_a: assert property (@(posedge clk) disable iff (!reset_n)
      mem_we |-> $past(mwe_q))
      else $error("write pulse without master enable");
   // A second strobe during a write must not pulse the array again.
   strobe_ignore_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_ctl && wstrobe_q) |=> !mem_we)
      else $error("strobe restarted a running write");
   // Power-down keeps the timing oscillator alive once it runs.
   osc_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (osc_run && power_down) |=> osc_run)
      else $error("oscillator stopped in power-down");
   // No disable here: reset is exactly the case under watch.
   rst_write_a: assert property (@(posedge clk)
      (!reset_n && wstrobe_q && !osc_tick) |=> wstrobe_q)
      else $error("reset cut a running write");

   write_c: cover property (@(posedge clk) disable iff (!reset_n)
      start_wr);
   read_c: cover property (@(posedge clk) disable iff (!reset_n)
      do_read);
   done_c: cover property (@(posedge clk) disable iff (!reset_n)
      wstrobe_q ##1 !wstrobe_q);
   timeout_c: cover property (@(posedge clk) disable iff (!reset_n)
      mwe_q ##1 !mwe_q);
   ready_c: cover property (@(posedge clk) disable iff (!reset_n)
      $rose(rdy_q));

endmodule
`default_nettype wire

// ==== tb/nbc_mem_model.sv ====
// Behavioural model of the 512-byte storage array behind the block.
`timescale 1ns/1ps
`default_nettype none
module nbc_mem_model (
   // Clock
   input  wire logic       clk,
   // Write port
   input  wire logic       mem_we,
   input  wire logic [8:0] mem_addr,
   input  wire logic [7:0] mem_wdata,
   // Read port, indexed by the address the bench has loaded
   input  wire logic [8:0] rd_addr,
   output logic [7:0]      mem_rdata
);
   logic [7:0] mem [512];

   // A fixed pattern, so an unwritten byte never reads back as a match.
   initial begin
      for (int i = 0; i < 512; i++) begin
         mem[i] = 8'(i) ^ 8'h3C;
      end
   end
   always @(posedge clk) begin
      if (mem_we === 1'b1) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
   assign mem_rdata = mem[rd_addr];
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the nonvolatile byte access control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import nbc_pkg::*;
   localparam int WCYC = 40;
   localparam int ODIV = 4;
   typedef struct {logic [8:0] a; logic [7:0] d; logic [7:0] e;} nbc_row_t;
   logic       clk, reset_n, io_wr, io_rd, gie, fbusy, pdown;
   logic       cpu_stall, ready_irq, mem_we, osc_run;
   logic [1:0] io_sel;
   logic [7:0] io_wdata, io_rdata, mem_wdata, mem_rdata, v;
   logic [8:0] mem_addr, cur_addr;
   int         fail_count = 0, cmp_count = 0, we_cnt = 0, st_cnt = 0;
   int         cyc = 0, s0, w0, t0, n;
   nbc_row_t   rows [3] = '{'{9'h000, 8'hA5, 8'hA5},
      '{9'h1FF, 8'h5A, 8'h5A}, '{9'h100, 8'h96, 8'h96}};

   nbc_access #(.WRITE_CLK_CYC(WCYC), .OSC_DIV(ODIV)) dut (
      .clk(clk), .reset_n(reset_n), .io_wr(io_wr), .io_rd(io_rd),
      .io_sel(io_sel), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .global_int_enable(gie), .flash_self_program_enable(fbusy),
      .power_down(pdown), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .osc_run(osc_run));
   nbc_mem_model mem (.clk(clk), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .rd_addr(cur_addr), .mem_rdata(mem_rdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      we_cnt <= we_cnt + int'(mem_we === 1'b1);
      st_cnt <= st_cnt + int'(cpu_stall === 1'b1);
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [8:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      @(negedge clk);
      io_wr = 1'b1;
      io_sel = s;
      io_wdata = d;
      if (s == NBC_SEL_ADDR_HIGH) cur_addr[8] = d[0];
      if (s == NBC_SEL_ADDR_LOW) cur_addr[7:0] = d;
      @(negedge clk);
      io_wr = 1'b0;
   endtask
   task automatic rd(input logic [1:0] s, output logic [7:0] q);
      @(negedge clk);
      io_sel = s;
      io_rd = 1'b1;
      repeat (2) @(negedge clk);
      q = io_rdata;
      io_rd = 1'b0;
   endtask
   // Software must see the strobe low before any new access.
   task automatic wait_idle();
      n = 0;
      do begin
         rd(NBC_SEL_CONTROL, v);
         n++;
      end while (v[1] !== 1'b0 && n < 200);
      if (n >= 200) fail_count++;
   endtask
   task automatic load(input logic [8:0] a);
      wait_idle();
      wr(NBC_SEL_ADDR_HIGH, {7'h00, a[8]});
      wr(NBC_SEL_ADDR_LOW, a[7:0]);
   endtask
   task automatic start_write(input logic [8:0] a, input logic [7:0] d);
      load(a);
      wr(NBC_SEL_DATA, d);
      wr(NBC_SEL_CONTROL, 8'h04);
      s0 = st_cnt;
      w0 = we_cnt;
      wr(NBC_SEL_CONTROL, 8'h02);
      t0 = cyc;
   endtask
   task automatic read_byte(input logic [8:0] a, input logic [7:0] e);
      load(a);
      s0 = st_cnt;
      wr(NBC_SEL_CONTROL, 8'h01);
      rd(NBC_SEL_DATA, v);
      chk("read data", {1'b0, v}, {1'b0, e});
      repeat (4) @(negedge clk);
      chk("read stall", 9'(st_cnt - s0), 9'(NBC_READ_STALL_CYC));
   endtask
   task automatic results();
      if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Budget is far above the expected run of about 500 cycles.
   initial begin
      #300us;
      fail_count++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {io_wr, io_rd, gie, fbusy, pdown, reset_n} = 6'h00;
      io_sel = 2'h0;
      io_wdata = 8'h00;
      cur_addr = 9'h000;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      rd(NBC_SEL_CONTROL, v);
      chk("ctrl reset", {1'b0, v}, {1'b0, NBC_CONTROL_RESET});
      foreach (rows[i]) begin
         start_write(rows[i].a, rows[i].d);
         repeat (6) @(negedge clk);
         chk("we pulses", 9'(we_cnt - w0), 9'h001);
         chk("wr stall", 9'(st_cnt - s0), 9'(NBC_WRITE_STALL_CYC));
         chk("mem addr", mem_addr, rows[i].a);
         chk("mem data", {1'b0, mem_wdata}, {1'b0, rows[i].d});
         rd(NBC_SEL_CONTROL, v);
         chk("busy ctrl", {1'b0, v}, 9'h002);
         read_byte(rows[i].a, rows[i].e);
      end
      rd(NBC_SEL_CONTROL, v);
      chk("read self clr", {1'b0, v}, 9'h000);
      wr(NBC_SEL_ADDR_HIGH, 8'hFF);
      rd(NBC_SEL_ADDR_HIGH, v);
      chk("addr high", {1'b0, v}, 9'h001);
      wr(NBC_SEL_CONTROL, 8'hF0);
      rd(NBC_SEL_CONTROL, v);
      chk("ctrl upper", {1'b0, v}, 9'h000);
      w0 = we_cnt;
      wr(NBC_SEL_CONTROL, 8'h04);
      rd(NBC_SEL_CONTROL, v);
      chk("mwe set", {1'b0, v}, 9'h004);
      repeat (3) @(negedge clk);
      wr(NBC_SEL_CONTROL, 8'h02);
      rd(NBC_SEL_CONTROL, v);
      chk("late strobe", {1'b0, v}, 9'h000);
      fbusy = 1'b1;
      wr(NBC_SEL_CONTROL, 8'h04);
      wr(NBC_SEL_CONTROL, 8'h02);
      repeat (3) @(negedge clk);
      fbusy = 1'b0;
      chk("no write", 9'(we_cnt - w0), 9'h000);
      start_write(9'h0AB, 8'h77);
      wr(NBC_SEL_ADDR_LOW, 8'h12);
      rd(NBC_SEL_ADDR_LOW, v);
      chk("addr locked", {1'b0, v}, 9'h0AB);
      wr(NBC_SEL_CONTROL, 8'h04);
      wr(NBC_SEL_CONTROL, 8'h02);
      pdown = 1'b1;
      @(negedge clk);
      chk("osc run", {8'h00, osc_run}, 9'h001);
      wait_idle();
      n = cyc - t0;
      chk("span", 9'(n >= WCYC && n <= WCYC + ODIV + 6), 9'h001);
      chk("one write", 9'(we_cnt - w0), 9'h001);
      chk("osc stays", {8'h00, osc_run}, 9'h001);
      pdown = 1'b0;
      repeat (2) @(negedge clk);
      chk("osc off", {8'h00, osc_run}, 9'h000);
      read_byte(9'h0AB, 8'h77);
      start_write(9'h1F0, 8'hC3);
      gie = 1'b1;
      wr(NBC_SEL_CONTROL, 8'h08);
      repeat (2) @(negedge clk);
      chk("irq busy", {8'h00, ready_irq}, 9'h000);
      wait_idle();
      repeat (2) @(negedge clk);
      chk("irq ready", {8'h00, ready_irq}, 9'h001);
      gie = 1'b0;
      repeat (2) @(negedge clk);
      chk("irq gie off", {8'h00, ready_irq}, 9'h000);
      start_write(9'h155, 8'h4E);
      @(negedge clk);
      reset_n = 1'b0;
      @(negedge clk);
      reset_n = 1'b1;
      rd(NBC_SEL_CONTROL, v);
      chk("strobe kept", {1'b0, v}, 9'h002);
      read_byte(9'h155, 8'h4E);
      results();
   end
endmodule
`default_nettype wire
